/* design/err_report_defs.svh */
// Constants of the recoverable error report encoder.
// Assumes inclusion by bare name from the package and the design.
`ifndef ERR_REPORT_DEFS_SVH
`define ERR_REPORT_DEFS_SVH
// Sizes
`define ERR_NPROC 4
`define ERR_PROC_W 2
`define ERR_ADDR_W 32
`define ERR_GSTAT_W 4
// Register byte offsets
`define OFF_STATUS 8'h00
`define OFF_ADDR 8'h04
`define OFF_MISC 8'h08
`define OFF_GLOBAL 8'h0C
`define OFF_CTRL 8'h10
// Error code values
`define CODE_SCRUB_HI 12'h00C
`define CHAN_GENERIC 4'hF
`define CODE_WB 16'h017A
`define CODE_LOAD 16'h0134
`define CODE_FETCH 16'h0150
`define CODE_FILTER_BIT 12
// Bank status flag positions
`define ST_VAL 31
`define ST_OVER 30
`define ST_UC 29
`define ST_EN 28
`define ST_MISC_INFO_VALID 27
`define ST_ADDRESS_VALID 26
`define ST_PCC 25
`define ST_S 24
`define ST_AR 23
// Bank misc fields
`define MISC_MODE_LSB 6
`define MISC_MODE_PHYS 3'h2
// Error class one-hot positions
`define CLS_SCRUB 0
`define CLS_WB 1
`define CLS_LOAD 2
`define CLS_FETCH 3
// Control bits and reset values
`define CTRL_LOCAL_EN 0
`define RST_WORD 32'h0000_0000
`endif

/* design/err_report_pkg.sv */
// Types of the recoverable error report encoder.
// Assumes the constants header is on the include path.
`include "err_report_defs.svh"
package err_report_pkg;
    // One detected error from the detecting unit
    typedef struct packed {
        logic valid;
        logic [3:0] err_class;
        logic [3:0] channel;
        logic chan_known;
        logic [`ERR_ADDR_W-1:0] addr;
        logic [5:0] addr_lsb;
        logic continuable;
        logic [`ERR_PROC_W-1:0] proc;
    } err_event_t;
    // Global check status of one logical processor
    typedef struct packed {
        logic local_delivery_flag;
        logic in_progress;
        logic error_pointer_valid;
        logic restart_pointer_valid;
    } proc_flags_t;
    // Whole state of the encoder
    typedef struct packed {
        logic [31:0] bank_status;
        logic [`ERR_ADDR_W-1:0] bank_addr;
        logic [31:0] bank_misc;
        proc_flags_t [`ERR_NPROC-1:0] gstat;
        logic local_en;
        logic [`ERR_NPROC-1:0] check_event;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
    } state_t;
endpackage : err_report_pkg

/* design/recoverable_error_report_encoder.sv */
// Recoverable error report encoder with an AHB-Lite register slave.
// Assumes the detecting unit runs on CLK_I and pulses one event a cycle.
//
// Behaviour
// - Scrub error logs code 00Cx, channel number or generic 1111 in x.
// - Cache writeback error logs code 17A: eviction, generic, level two.
// - Data load error logs code 134: data read, data, level zero.
// - Instruction fetch error logs code 150: fetch, instruction, level 0.
// - Filtering bit 12 of the logged code is always zero.
// - Action-optional: set VAL UC EN MISC_INFO_VALID ADDRESS_VALID S, clear OVER CONTEXT_CORRUPT_FLAG AR.
// - Action-required: as action-optional but action-required flag set.
// - Scrub and writeback errors load the physical address register.
// - Load and fetch errors also give address through misc and address.
// - Misc holds physical address mode 010b and the lowest valid bit.
// - Action-optional: every processor that receives the event gets restart valid, error invalid.
// - Broadcast event unless local delivery is supported and enabled.
// - Local-only delivery is flagged in the global check status.
// - One shared bank status seen alike by all processors.
// - The consuming processor is the affected one for required errors.
// - Continuable required error: restart and error pointers both valid.
// - Non-continuable required error: restart pointer invalid.
// - Observers of a required error: restart valid, error invalid.
// - A repeated error on the same instruction raises another event.
`timescale 1ns/1ps
`include "err_report_defs.svh"
module recoverable_error_report_encoder #(
    parameter bit LOCAL_SUPPORT = 1'b1
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Error event from the detecting unit
    input wire err_report_pkg::err_event_t ERR_EVENT_I,
    // Check event and logged information
    output logic [`ERR_NPROC-1:0] CHECK_EVENT_O,
    output logic [31:0] STATUS_O,
    output logic [`ERR_ADDR_W-1:0] ADDR_O,
    output logic [31:0] MISC_O,
    output err_report_pkg::proc_flags_t [`ERR_NPROC-1:0] GSTAT_O
);

    ////////////////////////////////////////////////////////////////////////
    // State and event decode
    err_report_pkg::state_t s_reg;
    err_report_pkg::state_t s_next;
    logic [3:0] cls;
    logic ev;
    logic is_ao;
    logic is_ar;
    logic local_mode;
    logic addr_ok;
    logic [15:0] code;

    // Accept only a single class per event
    assign cls = ERR_EVENT_I.err_class;
    assign ev = ERR_EVENT_I.valid && cls != 4'h0 &&
                (cls & (cls - 4'h1)) == 4'h0;
    assign is_ao = cls[`CLS_SCRUB] | cls[`CLS_WB];
    assign is_ar = cls[`CLS_LOAD] | cls[`CLS_FETCH];
    assign local_mode = LOCAL_SUPPORT & s_reg.local_en;
    assign addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;

    ////////////////////////////////////////////////////////////////////////
    // Compound error code of the incoming class
    always_comb begin
        code = 16'h0000;
        if (cls[`CLS_SCRUB]) begin
            code = {`CODE_SCRUB_HI,
                    ERR_EVENT_I.chan_known ? ERR_EVENT_I.channel
                                           : `CHAN_GENERIC};
        end else if (cls[`CLS_WB]) begin
            code = `CODE_WB;
        end else if (cls[`CLS_LOAD]) begin
            code = `CODE_LOAD;
        end else if (cls[`CLS_FETCH]) begin
            code = `CODE_FETCH;
        end
        code[`CODE_FILTER_BIT] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: software clears, bus address phase, then event logging
    always_comb begin
        s_next = s_reg;
        s_next.check_event = '0;
        s_next.ready = 1'b1;
        // Data phase of a write
        if (s_reg.wr_pend) begin
            case (s_reg.wr_addr)
                `OFF_STATUS: begin
                    s_next.bank_status = `RST_WORD;
                end
                `OFF_GLOBAL: begin
                    for (int p = 0; p < `ERR_NPROC; p++) begin
                        if (HWDATA_I[p*`ERR_GSTAT_W + 2]) begin
                            s_next.gstat[p].in_progress = 1'b0;
                        end
                    end
                end
                `OFF_CTRL: begin
                    s_next.local_en = HWDATA_I[`CTRL_LOCAL_EN];
                end
                default: begin
                end
            endcase
        end
        // Address phase
        s_next.wr_pend = addr_ok & HWRITE_I;
        s_next.wr_addr = HADDR_I;
        if (addr_ok & ~HWRITE_I) begin
            case (HADDR_I)
                `OFF_STATUS: s_next.rdata = s_reg.bank_status;
                `OFF_ADDR: s_next.rdata = s_reg.bank_addr;
                `OFF_MISC: s_next.rdata = s_reg.bank_misc;
                `OFF_GLOBAL: s_next.rdata = 32'(s_reg.gstat);
                `OFF_CTRL: s_next.rdata = {31'h0, s_reg.local_en};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
        // Event logging wins over any software clear of the same cycle
        if (ev) begin
            // One shared bank holds the error for every sharer
            s_next.bank_status = {16'h0000, code};
            s_next.bank_status[`ST_VAL] = 1'b1;
            s_next.bank_status[`ST_OVER] = 1'b0;
            s_next.bank_status[`ST_UC] = 1'b1;
            s_next.bank_status[`ST_EN] = 1'b1;
            s_next.bank_status[`ST_MISC_INFO_VALID] = 1'b1;
            s_next.bank_status[`ST_ADDRESS_VALID] = 1'b1;
            s_next.bank_status[`ST_PCC] = 1'b0;
            s_next.bank_status[`ST_S] = 1'b1;
            s_next.bank_status[`ST_AR] = is_ar;
            s_next.bank_addr = ERR_EVENT_I.addr;
            s_next.bank_misc = {23'h0, `MISC_MODE_PHYS,
                                ERR_EVENT_I.addr_lsb};
            for (int p = 0; p < `ERR_NPROC; p++) begin
                // Local delivery reaches only the affected processor
                if (!local_mode ||
                    p[`ERR_PROC_W-1:0] == ERR_EVENT_I.proc) begin
                    s_next.check_event[p] = 1'b1;
                    s_next.gstat[p].in_progress = 1'b1;
                    s_next.gstat[p].local_delivery_flag =
                        local_mode;
                    if (is_ar &&
                        p[`ERR_PROC_W-1:0] == ERR_EVENT_I.proc) begin
                        // Affected processor of a required error
                        s_next.gstat[p].restart_pointer_valid =
                            ERR_EVENT_I.continuable;
                        s_next.gstat[p].error_pointer_valid =
                            1'b1;
                    end else begin
                        // Reporter of optional errors and all observers
                        s_next.gstat[p].restart_pointer_valid =
                            1'b1;
                        s_next.gstat[p].error_pointer_valid =
                            1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_reg <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register, except HRESP_O tied to OKAY
    assign HRDATA_O = s_reg.rdata;
    assign HREADYOUT_O = s_reg.ready;
    assign HRESP_O = 1'b0; // Always OKAY
    assign CHECK_EVENT_O = s_reg.check_event;
    assign STATUS_O = s_reg.bank_status;
    assign ADDR_O = s_reg.bank_addr;
    assign MISC_O = s_reg.bank_misc;
    assign GSTAT_O = s_reg.gstat;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // Helper: processor of the previous event
    logic [`ERR_PROC_W-1:0] last_proc;
    always_ff @(posedge CLK_I) begin
        last_proc <= ERR_EVENT_I.proc;
    end

    // Event raised and logged together in the next cycle with the flags of a class
    sequence s_raise;
        ##1 (CHECK_EVENT_O != '0);
    endsequence
    sequence s_ao_logged;
        ##1 (STATUS_O[31:23] == 9'b1011_1101_0);
    endsequence
    sequence s_ar_logged;
        ##1 (STATUS_O[31:23] == 9'b1011_1101_1);
    endsequence

    property p_scrub_code;
        ev && cls[`CLS_SCRUB] |=> STATUS_O[15:0] ==
            {12'h00C, $past(ERR_EVENT_I.chan_known) ?
             $past(ERR_EVENT_I.channel) : 4'hF};
    endproperty
    a_scrub_code: assert property (p_scrub_code)
        else $error("scrub code wrong");

    property p_wb_code;
        ev && cls[`CLS_WB] |=> STATUS_O[15:0] == 16'h017A;
    endproperty
    a_wb_code: assert property (p_wb_code)
        else $error("writeback code wrong");

    property p_load_code;
        ev && cls[`CLS_LOAD] |=> STATUS_O[15:0] == 16'h0134;
    endproperty
    a_load_code: assert property (p_load_code)
        else $error("load code wrong");

    property p_fetch_code;
        ev && cls[`CLS_FETCH] |=> STATUS_O[15:0] == 16'h0150;
    endproperty
    a_fetch_code: assert property (p_fetch_code)
        else $error("fetch code wrong");

    property p_filter_bit;
        CHECK_EVENT_O != '0 |-> !STATUS_O[12];
    endproperty
    a_filter_bit: assert property (p_filter_bit)
        else $error("filter bit set");

    property p_ao_flags;
        ev && is_ao |-> s_ao_logged and s_raise;
    endproperty
    a_ao_flags: assert property (p_ao_flags)
        else $error("optional status flags wrong");

    property p_ar_flags;
        ev && is_ar |-> s_ar_logged and s_raise;
    endproperty
    a_ar_flags: assert property (p_ar_flags)
        else $error("required status flags wrong");

    property p_addr_misc;
        ev |=> ADDR_O == $past(ERR_EVENT_I.addr) &&
            MISC_O[8:6] == 3'h2 && MISC_O[5:0] == $past(ERR_EVENT_I.addr_lsb);
    endproperty
    a_addr_misc: assert property (p_addr_misc)
        else $error("address or misc wrong");

    property p_ao_global;
        ev && is_ao && !local_mode |=>
            GSTAT_O[0].restart_pointer_valid &&
            !GSTAT_O[0].error_pointer_valid &&
            GSTAT_O[`ERR_NPROC-1].restart_pointer_valid &&
            !GSTAT_O[`ERR_NPROC-1].error_pointer_valid;
    endproperty
    a_ao_global: assert property (p_ao_global)
        else $error("optional pointer flags wrong");

    property p_delivery;
        ev |=> ($past(local_mode) ? $onehot(CHECK_EVENT_O) :
                (&CHECK_EVENT_O));
    endproperty
    a_delivery: assert property (p_delivery)
        else $error("delivery scope wrong");

    property p_local_flag;
        ev |=> GSTAT_O[last_proc].local_delivery_flag == $past(local_mode);
    endproperty
    a_local_flag: assert property (p_local_flag)
        else $error("local delivery flag wrong");

    property p_ar_affected;
        ev && is_ar |=>
            GSTAT_O[last_proc].restart_pointer_valid ==
            $past(ERR_EVENT_I.continuable) &&
            GSTAT_O[last_proc].error_pointer_valid;
    endproperty
    a_ar_affected: assert property (p_ar_affected)
        else $error("affected pointer flags wrong");

    property p_ar_observer;
        ev && is_ar && !local_mode && ERR_EVENT_I.proc != '0 |=>
            GSTAT_O[0].restart_pointer_valid &&
            !GSTAT_O[0].error_pointer_valid;
    endproperty
    a_ar_observer: assert property (p_ar_observer)
        else $error("observer pointer flags wrong");

    property p_repeat;
        ev ##1 ev |-> s_raise;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeated error not raised");

    property p_pulse;
        !ev |=> CHECK_EVENT_O == '0;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("event raised without cause");

    property p_status_read;
        addr_ok && !HWRITE_I && HADDR_I == `OFF_STATUS |=>
            HRDATA_O == $past(STATUS_O);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("shared status read wrong");

    property p_status_clear;
        s_reg.wr_pend && s_reg.wr_addr == `OFF_STATUS && !ev |=>
            STATUS_O == `RST_WORD;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status clear lost");

    property p_in_progress;
        ev |=> GSTAT_O[last_proc].in_progress;
    endproperty
    a_in_progress: assert property (p_in_progress)
        else $error("in-progress flag not set");

endmodule : recoverable_error_report_encoder

/* test/test_recoverable_error_report_encoder.sv */
// Self-checking bench of the recoverable error report encoder.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps
module test_recoverable_error_report_encoder;
    // Expected outputs of one check event
    typedef struct packed {
        logic [3:0] ce;
        logic [31:0] st;
        logic [31:0] ad;
        logic [31:0] mi;
        logic [15:0] gs;
    } note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    err_report_pkg::err_event_t ev = '0;
    logic [3:0] check_event;
    logic [31:0] status, bank_addr, misc;
    err_report_pkg::proc_flags_t [3:0] gstat;
    err_report_pkg::proc_flags_t [3:0] exp_g = '0;
    logic [31:0] exp_st = 32'h0000_0000;
    logic [31:0] exp_ad = 32'h0000_0000;
    logic [31:0] exp_mi = 32'h0000_0000;
    logic [31:0] rd;
    logic lcl = 1'b0;
    note_t note_q[$];
    int error_cnt = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and device
    always #12.5 clk = ~clk;
    wire logic hready_o_w;
    assign hready = hready_o_w;
    recoverable_error_report_encoder #(.LOCAL_SUPPORT(1'b1)) i_dut (
        .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready_o_w), .HRESP_O(hresp), .ERR_EVENT_I(ev),
        .CHECK_EVENT_O(check_event), .STATUS_O(status), .ADDR_O(bank_addr),
        .MISC_O(misc), .GSTAT_O(gstat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One AHB-Lite single word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        r = hrdata;
        chk(32'(hresp), 32'h0, "bus response");
        if (n >= 100) begin
            error_cnt++;
            $display("[FAIL] %0t bus wait ran out", $time);
            end_sim();
        end
    endtask : bus

    // Random error of one class
    function automatic err_report_pkg::err_event_t rnd_ev(input int c);
        err_report_pkg::err_event_t e;
        e.valid = 1'b1;
        e.err_class = 4'h1 << c;
        e.channel = 4'($urandom_range(14));
        e.chan_known = 1'($urandom);
        e.addr = $urandom;
        e.addr_lsb = 6'($urandom);
        e.continuable = 1'($urandom);
        e.proc = 2'($urandom);
        return e;
    endfunction : rnd_ev

    // Drive one event and note what it must produce
    task automatic fire(input err_report_pkg::err_event_t e);
        logic req;
        logic [15:0] code;
        logic [3:0] rcp;
        req = e.err_class[2] | e.err_class[3];
        code = e.err_class[0] ? {8'h00, 4'hC, e.chan_known ? e.channel : 4'hF}
             : e.err_class[1] ? 16'h017A
             : e.err_class[2] ? 16'h0134 : 16'h0150;
        exp_st = 32'hBD00_0000 | (req ? 32'h0080_0000 : 32'h0) | code;
        exp_ad = e.addr;
        exp_mi = {23'h0, 3'h2, e.addr_lsb};
        rcp = lcl ? (4'h1 << e.proc) : 4'hF;
        for (int p = 0; p < 4; p++) begin
            if (rcp[p]) begin
                exp_g[p] = {lcl, 1'b1, req && p == e.proc,
                            (req && p == e.proc) ? e.continuable : 1'b1};
            end
        end
        ev <= e;
        note_q.push_back({rcp, exp_st, exp_ad, exp_mi, 16'(exp_g)});
    endtask : fire

    ////////////////////////////////////////////////////////////////////////
    // Output watcher: each pulse takes the oldest note
    always @(negedge clk) begin : mon
        note_t n;
        if (!rst && check_event !== 4'h0) begin
            if (note_q.size() == 0) begin
                error_cnt++;
                $display("[FAIL] %0t check event without cause", $time);
            end else begin
                n = note_q.pop_front();
                chk(32'(check_event), 32'(n.ce), "recipients");
                chk(status, n.st, "bank status");
                chk(bank_addr, n.ad, "bank address");
                chk(misc, n.mi, "bank misc");
                chk(32'(gstat), 32'(n.gs), "global flags");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(65));
        repeat (20) @(posedge clk);
        chk(status, 32'h0, "reset status");
        chk(32'(gstat), 32'h0, "reset flags");
        chk(32'(hready), 32'h1, "reset ready");
        rst <= 1'b0;
        @(posedge clk);
        // Broadcast delivery, back to back, every class
        for (int i = 0; i < 12; i++) begin
            fire(rnd_ev(i % 4));
            @(posedge clk);
        end
        ev <= '0;
        @(posedge clk);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk(rd, exp_st, "status read");
        bus(1'b0, 8'h04, 32'h0, rd);
        chk(rd, exp_ad, "address read");
        bus(1'b1, 8'h04, 32'hFFFF_FFFF, rd);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk(rd, exp_ad, "address read only");
        bus(1'b0, 8'h08, 32'h0, rd);
        chk(rd, exp_mi, "misc read");
        bus(1'b0, 8'h14, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        // Clear one processor's in-progress flag and the shared bank
        bus(1'b1, 8'h0C, 32'h0000_0400, rd);
        exp_g[2].in_progress = 1'b0;
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk(rd, 32'(exp_g), "global read");
        bus(1'b1, 8'h00, 32'h0, rd);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 32'h0, "status cleared");
        // Local delivery to the affected processor only
        bus(1'b1, 8'h10, 32'h0000_0001, rd);
        lcl = 1'b1;
        bus(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h1, "control read");
        for (int i = 0; i < 8; i++) begin
            fire(rnd_ev(i % 4));
            @(posedge clk); // Next event in the following cycle, back to back
        end
        ev <= '0;
        @(posedge clk);
        // Two class bits at once raise nothing
        ev <= '{valid: 1'b1, err_class: 4'h3, default: '0};
        @(posedge clk);
        ev <= '0;
        repeat (3) @(posedge clk);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk(rd, exp_st, "status after bad class");
        chk(32'(note_q.size()), 32'h0, "missing events");
        end_sim();
    end
endmodule : test_recoverable_error_report_encoder
